// file: bench/crf_core_assertions.sv
// Port checks for the core register file and fetch block.
`timescale 1ns/1ps
module crf_core_assertions (
	input wire        core_clk, rst, ld_valid, ld_signed, ld_word_valid, wr_en, wr_seq,
	input wire        exc_valid, alu_go, alu_valid, ea_go, ea_valid, rd_en, rd_operand,
	input wire        rd_bad_operand, mem_rd_req, mem_ack, cache_hit_seen,
	input wire [1:0]  ld_size, current_level_field, exception_class_field,
	input wire [2:0]  alu_op,
	input wire [3:0]  exc_code, q_count,
	input wire [4:0]  wr_idx, rd_a_idx,
	input wire [31:0] ld_word, alu_a, alu_b, alu_result, ea_base, ea_disp,
	input wire [31:0] address_arith_unit, mem_addr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire priv_w = wr_en && !wr_seq && (wr_idx >= 5'h18 || wr_idx == 5'h0b ||
		wr_idx == 5'h0d || wr_idx == 5'h0e);
	sequence s_wait; mem_rd_req && !mem_ack; endsequence
	sequence s_hit; cache_hit_seen; endsequence
	ld_pulse_a: assert property (ld_valid |=> ld_word_valid) else $error("no load");
	zero_fill_a: assert property (ld_valid && ld_size == 2'h0 && !ld_signed |=>
		ld_word[31:8] == 24'h00_0000) else $error("zero fill");
	sign_fill_a: assert property (ld_valid && ld_size == 2'h1 && ld_signed |=>
		ld_word[31:16] == {16{ld_word[15]}}) else $error("sign fill");
	queue_cap_a: assert property (q_count <= 4'h8) else $error("queue over");
	hit_quiet_a: assert property (s_hit |-> !mem_rd_req [*4]) else $error("hit read");
	req_hold_a: assert property (s_wait |=> mem_rd_req && $stable(mem_addr) &&
		mem_addr[1:0] == 2'h0) else $error("req dropped");
	priv_trap_a: assert property (priv_w && current_level_field != 2'h0 |=>
		exc_valid && exception_class_field == 2'h3 && exc_code == 4'hf) else $error("trap");
	add_sum_a: assert property (alu_go && alu_op == 3'h0 |=> alu_valid &&
		alu_result == $past(alu_a) + $past(alu_b)) else $error("add");
	ea_sum_a: assert property (ea_go |=> ea_valid &&
		address_arith_unit == $past(ea_base) + $past(ea_disp)) else $error("ea");
	bad_operand_a: assert property (rd_en && rd_operand |=> rd_bad_operand ==
		($past(rd_a_idx) == 5'h0f || $past(rd_a_idx) == 5'h0b)) else $error("operand");
endmodule // crf_core_assertions

// file: bench/crf_core_tb.sv
// Self-checking bench for the core register file and fetch block.
`timescale 1ns/1ps
module crf_core_tb;
	reg core_clk=0, rst=1, rd_en=0, rd_operand=0, wr_en=0, wr_seq=0, ld_valid=0, ld_signed=0;
	reg alu_go=0, ea_go=0, fetch_req=0, q_pop=0, cache_flush=0;
	reg [4:0] rd_a_idx=0, rd_b_idx=0, wr_idx=0, a;
	reg [1:0] ld_size=0, ld_lane=0;
	reg [2:0] alu_op=0;
	reg [3:0] wait_cycles=0;
	reg [31:0] wr_data=0, ld_bus=0, alu_a=0, alu_b=0, ea_base=0, ea_disp=0, fetch_addr=0, x;
	reg [32:0] r;
	wire mem_ack, rd_bad_operand, exc_valid, ld_word_valid, alu_valid, ea_valid, mem_rd_req;
	wire fetch_busy, q_valid, cache_hit_seen;
	wire [31:0] mem_rdata, rd_a_data, rd_b_data, ld_word, alu_result, address_arith_unit, mem_addr;
	wire [1:0] exception_class_field, current_level_field;
	wire [3:0] exc_code, alu_flags, q_count;
	wire [7:0] q_byte;
	integer mismatches=0, n_compared=0, cyc=0, n_req=0, n_hit=0, i, j;
	crf_core crf_core_i (.*);
	crf_mem_model crf_mem_model_i (.*);
	initial forever #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		n_req = n_req + mem_ack;
		n_hit = n_hit + cache_hit_seen;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			print_verdict;
		end
	end
	task print_verdict;
		if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input [31:0] g, e);
		n_compared = n_compared + 1;
		if (g !== e) begin
			mismatches = mismatches + 1;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task step; @(negedge core_clk); endtask
	// One access: optional write plus a read of the same register.
	task acc(input w, input [4:0] ai, input [31:0] d, input s, op);
		wr_en = w; wr_idx = ai; wr_data = d; wr_seq = s; rd_operand = op;
		rd_en = 1; rd_a_idx = ai; rd_b_idx = ai;
		step;
		wr_en = 0; rd_en = 0; rd_operand = 0;
	endtask
	function [31:0] ext(input [31:0] b, input [1:0] sz, ln, input sg);
		reg [15:0] h;
		reg [7:0] c;
		begin
			c = b[31-8*ln -: 8];
			h = ln[1] ? b[15:0] : b[31:16];
			ext = sz == 2 ? b : sz == 1 ? {{16{sg & h[15]}}, h} : {{24{sg & c[7]}}, c};
		end
	endfunction
	// Expected 33-bit ALU outcome; bit 32 is the carry or borrow of add and subtract.
	function [32:0] alu_exp(input [2:0] op, input [31:0] p, q);
		reg [63:0] w;
		begin
			w = {p, p} << q[4:0];
			case (op)
			3'd0: alu_exp = {1'b0, p} + {1'b0, q};
			3'd1: alu_exp = {1'b0, p} - {1'b0, q};
			3'd2: alu_exp = {1'b0, p & q};
			3'd3: alu_exp = {1'b0, p | q};
			3'd4: alu_exp = {1'b0, p ^ q};
			3'd5: alu_exp = {1'b0, p << q[4:0]};
			3'd6: alu_exp = {1'b0, p >> q[4:0]};
			default: alu_exp = {1'b0, w[63:32]};
			endcase
		end
	endfunction
	task fetch(input [31:0] fa);
		fetch_addr = fa; fetch_req = 1;
		step;
		fetch_req = 0;
		for (j = 0; j < 60 && fetch_busy; j = j + 1) step;
		step;
	endtask
	task popw(input [31:0] fa);
		for (j = 0; j < 4; j = j + 1) begin
			x = fa ^ 32'h5a5a_c3c3;
			chk(q_byte, x[31-8*j -: 8]);
			q_pop = 1; step; q_pop = 0; step;
		end
	endtask
	initial begin
		x = $urandom(1143);
		repeat (12) @(posedge core_clk);
		@(negedge core_clk) rst = 0;
		for (i = 0; i < 24; i = i + 1) if (i < 9 || i > 15) begin
			x = $urandom; acc(1, i, x, 0, 0);
			chk(rd_a_data, x);
			chk(rd_b_data, x);
		end
		acc(1, 24, 32'h1234_5678, 0, 0); chk(exc_valid, 0);
		acc(1, 11, 32'h0000_1800, 0, 0); step; chk(current_level_field, 3);
		for (i = 0; i < 5; i = i + 1) begin
			a = i == 0 ? 24 : i == 1 ? 31 : i == 2 ? 11 : i == 3 ? 13 : 14;
			acc(1, a, 32'hdead_0000, 0, 0);
			chk({exc_valid, exception_class_field, exc_code}, 7'h7f);
		end
		acc(0, 24, 0, 0, 0); chk(rd_a_data, 32'h1234_5678);
		acc(1, 2, 32'h0000_0042, 0, 0); chk(exc_valid, 0);
		acc(1, 11, 32'h0000_0000, 1, 0); step; chk(current_level_field, 0);
		for (i = 9; i < 16; i = i + 1) begin
			acc(0, i, 0, 0, 1); chk(rd_bad_operand, i == 15 || i == 11);
		end
		for (i = 0; i < 60; i = i + 1) begin
			ld_bus = i < 4 ? 32'h8000_8080 : $urandom; ld_size = $urandom % 3;
			ld_lane = $urandom; ld_signed = $urandom; ld_valid = 1;
			alu_op = $urandom % 8; alu_a = i ? $urandom : 32'hffff_ffff; alu_b = i ? $urandom : 1;
			ea_base = $urandom; ea_disp = $urandom; alu_go = 1; ea_go = 1;
			step;
			ld_valid = 0; alu_go = 0; ea_go = 0;
			chk(ld_word, ext(ld_bus, ld_size, ld_lane, ld_signed));
			r = alu_exp(alu_op, alu_a, alu_b);
			chk(alu_result, r[31:0]);
			chk(alu_flags[3:2], {r[31], r[31:0] == 0});
			chk(alu_flags[1], (alu_op == 0 && alu_a[31] == alu_b[31] && r[31] != alu_a[31]) ||
				(alu_op == 1 && alu_a[31] != alu_b[31] && r[31] != alu_a[31]));
			if (alu_op < 2) chk(alu_flags[0], r[32]);
			chk(address_arith_unit, ea_base + ea_disp);
		end
		cache_flush = 1; step; cache_flush = 0;
		fetch(32'h0000_1004);
		wait_cycles = 5;
		fetch(32'h0000_2008);
		chk(q_count, 8);
		chk(q_valid, 1);
		chk(mem_addr, 32'h0000_2008);
		chk(n_req, 2);
		popw(32'h0000_1004);
		popw(32'h0000_2008);
		fetch(32'h0000_1004);
		chk(n_hit, 1);
		chk(n_req, 2);
		popw(32'h0000_1004);
		chk(q_count, 0);
		chk(q_valid, 0);
		print_verdict;
	end
endmodule // crf_core_tb
bind crf_core crf_core_assertions crf_core_assertions_i (.*);

// file: bench/crf_mem_model.sv
// External memory answering instruction reads after a chosen wait.
`timescale 1ns/1ps
module crf_mem_model (
	input  wire        core_clk, rst, mem_rd_req,
	input  wire [31:0] mem_addr,
	input  wire [3:0]  wait_cycles,
	output reg         mem_ack,
	output reg  [31:0] mem_rdata
);
	reg [3:0] wait_q;
	// Data toggles outside the answer cycle so stale data never looks valid.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0000_0000;
			wait_q <= 4'h0;
		end else begin
			mem_rdata <= ~mem_rdata;
			mem_ack <= 1'b0;
			if (mem_rd_req && !mem_ack) begin
				wait_q <= wait_q + 4'h1;
				if (wait_q == wait_cycles) begin
					mem_ack <= 1'b1;
					mem_rdata <= mem_addr ^ 32'h5a5a_c3c3;
					wait_q <= 4'h0;
				end
			end
		end
	end
endmodule // crf_mem_model

// file: hdl/crf_consts.vh
// Constants for the core register file and fetch buffer block.
`ifndef CRF_CONSTS_VH
`define CRF_CONSTS_VH
`define CRF_REG_FP       5'h09
`define CRF_REG_AP       5'h0a
`define CRF_REG_PSW      5'h0b
`define CRF_REG_SP       5'h0c
`define CRF_REG_PCBP     5'h0d
`define CRF_REG_ISP      5'h0e
`define CRF_REG_PC       5'h0f
`define CRF_REG_KBASE    5'h18
`define CRF_LVL_HI       12
`define CRF_LVL_LO       11
`define CRF_LVL_KERNEL   2'h0
`define CRF_EXC_NORMAL   2'h3
`define CRF_ISC_PRIVREG  4'hf
`define CRF_QUEUE_BYTES  8
`define CRF_CACHE_WORDS  64
`define CRF_SZ_BYTE      2'h0
`define CRF_SZ_HALF      2'h1
`define CRF_SZ_WORD      2'h2
`define CRF_PSW_RESET    32'h0000_0000
`endif

// file: hdl/crf_core.v
// Core register file, load extension, ALU, instruction queue and instruction cache.
`timescale 1ns/1ps
`include "crf_consts.vh"
module crf_core (
	input  wire        core_clk,
	input  wire        rst,
	input  wire        rd_en,
	input  wire [4:0]  rd_a_idx,
	input  wire [4:0]  rd_b_idx,
	input  wire        rd_operand,
	input  wire        wr_en,
	input  wire        wr_seq,
	input  wire [4:0]  wr_idx,
	input  wire [31:0] wr_data,
	input  wire        ld_valid,
	input  wire [1:0]  ld_size,
	input  wire        ld_signed,
	input  wire [1:0]  ld_lane,
	input  wire [31:0] ld_bus,
	input  wire        alu_go,
	input  wire [2:0]  alu_op,
	input  wire [31:0] alu_a,
	input  wire [31:0] alu_b,
	input  wire        ea_go,
	input  wire [31:0] ea_base,
	input  wire [31:0] ea_disp,
	input  wire        fetch_req,
	input  wire [31:0] fetch_addr,
	input  wire        mem_ack,
	input  wire [31:0] mem_rdata,
	input  wire        q_pop,
	input  wire        cache_flush,
	output reg  [31:0] rd_a_data,
	output reg  [31:0] rd_b_data,
	output reg         rd_bad_operand,
	output reg         exc_valid,
	output reg  [1:0]  exception_class_field,
	output reg  [3:0]  exc_code,
	output reg  [1:0]  current_level_field,
	output reg  [31:0] ld_word,
	output reg         ld_word_valid,
	output reg  [31:0] alu_result,
	output reg  [3:0]  alu_flags,
	output reg         alu_valid,
	output reg  [31:0] address_arith_unit,
	output reg         ea_valid,
	output reg         mem_rd_req,
	output reg  [31:0] mem_addr,
	output reg         fetch_busy,
	output reg  [7:0]  q_byte,
	output reg         q_valid,
	output reg  [3:0]  q_count,
	output reg         cache_hit_seen
);
	localparam ST_IDLE = 2'b00;
	localparam ST_MEM  = 2'b01;
	localparam ST_FILL = 2'b10;

	reg  [31:0] regs_q [0:31];
	reg  [7:0]  queue_q [0:7];
	reg  [2:0]  q_wr_q;
	reg  [2:0]  q_rd_q;
	reg  [3:0]  q_cnt_q;
	reg  [31:0] cache_data_q [0:63];
	reg  [23:0] cache_tag_q [0:63];
	reg  [63:0] cache_vld_q;
	reg  [1:0]  fst_q;
	reg  [31:0] fword_q;
	reg  [2:0]  fleft_q;
	reg  [31:0] fa_q;
	reg  [31:0] ld_d;
	reg  [32:0] sum_d;
	reg  [31:0] res_d;
	wire [5:0]  c_idx;
	wire        priv_dst;
	wire        kernel;
	wire        wr_ok;
	wire        hit;
	wire        q_do_pop;
	wire        q_do_push;
	integer     i;

	// Level comes from the live status word so a level change takes effect at once.
	assign kernel = (regs_q[`CRF_REG_PSW][`CRF_LVL_HI:`CRF_LVL_LO] == `CRF_LVL_KERNEL);
	assign priv_dst = (wr_idx >= `CRF_REG_KBASE) || (wr_idx == `CRF_REG_PSW) ||
			(wr_idx == `CRF_REG_PCBP) || (wr_idx == `CRF_REG_ISP);
	// Sequencer writes (scratch use of r2..r0, PC updates) bypass the level check.
	assign wr_ok = wr_en && (wr_seq || !priv_dst || kernel);

	// Read ports with write-through bypass.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rd_a_data <= 32'h0000_0000;
			rd_b_data <= 32'h0000_0000;
			rd_bad_operand <= 1'b0;
		end else if (rd_en) begin
			rd_a_data <= (wr_ok && wr_idx == rd_a_idx) ? wr_data : regs_q[rd_a_idx];
			rd_b_data <= (wr_ok && wr_idx == rd_b_idx) ? wr_data : regs_q[rd_b_idx];
			rd_bad_operand <= rd_operand && (rd_a_idx == `CRF_REG_PC ||
					rd_a_idx == `CRF_REG_PSW);
		end
	end

	// Thirty-two architectural registers; working registers are kept apart.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < 32; i = i + 1)
				regs_q[i] <= `CRF_PSW_RESET;
			exc_valid <= 1'b0;
			exception_class_field <= 2'h0;
			exc_code <= 4'h0;
			current_level_field <= 2'h0;
		end else begin
			exc_valid <= 1'b0;
			if (wr_ok) begin
				regs_q[wr_idx] <= wr_data;
			end else if (wr_en) begin
				exc_valid <= 1'b1;
				exception_class_field <= `CRF_EXC_NORMAL;
				exc_code <= `CRF_ISC_PRIVREG;
			end
			current_level_field <= (wr_ok && wr_idx == `CRF_REG_PSW) ?
					wr_data[`CRF_LVL_HI:`CRF_LVL_LO] :
					regs_q[`CRF_REG_PSW][`CRF_LVL_HI:`CRF_LVL_LO];
		end
	end

	// Load lane select and width extension; lane 0 is the high byte.
	always @* begin
		ld_d = ld_bus;
		case (ld_size)
		`CRF_SZ_BYTE: begin
			case (ld_lane)
			2'd0: ld_d = {24'h00_0000, ld_bus[31:24]};
			2'd1: ld_d = {24'h00_0000, ld_bus[23:16]};
			2'd2: ld_d = {24'h00_0000, ld_bus[15:8]};
			default: ld_d = {24'h00_0000, ld_bus[7:0]};
			endcase
			if (ld_signed)
				ld_d[31:8] = {24{ld_d[7]}};
		end
		`CRF_SZ_HALF: begin
			ld_d = ld_lane[1] ? {16'h0000, ld_bus[15:0]} : {16'h0000, ld_bus[31:16]};
			if (ld_signed)
				ld_d[31:16] = {16{ld_d[15]}};
		end
		default: ld_d = ld_bus;
		endcase
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ld_word <= 32'h0000_0000;
			ld_word_valid <= 1'b0;
		end else begin
			ld_word_valid <= ld_valid;
			if (ld_valid)
				ld_word <= ld_d;
		end
	end

	// 33-bit ALU: bit 32 carries the carry out of add and the borrow of subtract.
	always @* begin
		sum_d = 33'h0_0000_0000;
		res_d = 32'h0000_0000;
		case (alu_op)
		3'd0: sum_d = {1'b0, alu_a} + {1'b0, alu_b};
		3'd1: sum_d = {1'b0, alu_a} - {1'b0, alu_b};
		3'd2: sum_d = {1'b0, alu_a & alu_b};
		3'd3: sum_d = {1'b0, alu_a | alu_b};
		3'd4: sum_d = {1'b0, alu_a ^ alu_b};
		3'd5: sum_d = {alu_a, 1'b0} >> (6'd1 + {1'b0, alu_b[4:0]} - 6'd1);
		3'd6: sum_d = {1'b0, alu_a >> alu_b[4:0]};
		default: sum_d = {1'b0, (alu_a << alu_b[4:0]) | (alu_a >> (6'd32 - {1'b0, alu_b[4:0]}))};
		endcase
		res_d = sum_d[31:0];
		if (alu_op == 3'd5)
			res_d = alu_a << alu_b[4:0];
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			alu_result <= 32'h0000_0000;
			alu_flags <= 4'h0;
			alu_valid <= 1'b0;
		end else begin
			alu_valid <= alu_go;
			if (alu_go) begin
				alu_result <= res_d;
				alu_flags[3] <= res_d[31];
				alu_flags[2] <= (res_d == 32'h0000_0000);
				alu_flags[1] <= (alu_op == 3'd0) ? (alu_a[31] == alu_b[31] && res_d[31] != alu_a[31]) :
						(alu_op == 3'd1) ? (alu_a[31] != alu_b[31] && res_d[31] != alu_a[31]) : 1'b0;
				alu_flags[0] <= (alu_op <= 3'd1) ? sum_d[32] : 1'b0;
			end
		end
	end

	// Effective address unit.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			address_arith_unit <= 32'h0000_0000;
			ea_valid <= 1'b0;
		end else begin
			ea_valid <= ea_go;
			if (ea_go)
				address_arith_unit <= ea_base + ea_disp;
		end
	end

	// Direct-mapped cache indexed by word address bits.
	assign c_idx = fetch_addr[7:2];
	assign hit = cache_vld_q[c_idx] && (cache_tag_q[c_idx] == fetch_addr[31:8]);
	// A fill pushes a byte whenever one byte is free or a pop frees one in the same cycle.
	assign q_do_pop = q_pop && (q_cnt_q != 4'd0);
	assign q_do_push = (fst_q == ST_FILL) && (q_cnt_q != 4'd8 || q_do_pop);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fst_q <= ST_IDLE;
			fword_q <= 32'h0000_0000;
			fleft_q <= 3'd0;
			fa_q <= 32'h0000_0000;
			cache_vld_q <= 64'h0000_0000_0000_0000;
			mem_rd_req <= 1'b0;
			mem_addr <= 32'h0000_0000;
			fetch_busy <= 1'b0;
			cache_hit_seen <= 1'b0;
			q_wr_q <= 3'd0;
			q_rd_q <= 3'd0;
			q_cnt_q <= 4'd0;
			q_byte <= 8'h00;
			q_valid <= 1'b0;
			q_count <= 4'h0;
			for (i = 0; i < 64; i = i + 1) begin
				cache_data_q[i] <= 32'h0000_0000;
				cache_tag_q[i] <= 24'h00_0000;
			end
			for (i = 0; i < 8; i = i + 1)
				queue_q[i] <= 8'h00;
		end else begin
			cache_hit_seen <= 1'b0;
			if (cache_flush)
				cache_vld_q <= 64'h0000_0000_0000_0000;
			case (fst_q)
			ST_IDLE: begin
				if (fetch_req) begin
					fetch_busy <= 1'b1;
					fa_q <= fetch_addr;
					if (hit && !cache_flush) begin
						fword_q <= cache_data_q[c_idx];
						cache_hit_seen <= 1'b1;
						fleft_q <= 3'd4;
						fst_q <= ST_FILL;
					end else begin
						mem_rd_req <= 1'b1;
						mem_addr <= {fetch_addr[31:2], 2'b00};
						fst_q <= ST_MEM;
					end
				end
			end
			ST_MEM: begin
				if (mem_ack) begin
					mem_rd_req <= 1'b0;
					fword_q <= mem_rdata;
					cache_data_q[fa_q[7:2]] <= mem_rdata;
					cache_tag_q[fa_q[7:2]] <= fa_q[31:8];
					cache_vld_q[fa_q[7:2]] <= !cache_flush;
					fleft_q <= 3'd4;
					fst_q <= ST_FILL;
				end
			end
			ST_FILL: begin
				if (q_do_push) begin
					fword_q <= {fword_q[23:0], 8'h00};
					fleft_q <= fleft_q - 3'd1;
					if (fleft_q == 3'd1) begin
						fst_q <= ST_IDLE;
						fetch_busy <= 1'b0;
					end
				end
			end
			default: fst_q <= ST_IDLE;
			endcase
			// Eight-byte FIFO queue.
			if (q_do_push) begin
				queue_q[q_wr_q] <= fword_q[31:24];
				q_wr_q <= q_wr_q + 3'd1;
			end
			if (q_do_pop)
				q_rd_q <= q_rd_q + 3'd1;
			q_cnt_q <= q_cnt_q + {3'd0, q_do_push} - {3'd0, q_do_pop};
			q_count <= q_cnt_q + {3'd0, q_do_push} - {3'd0, q_do_pop};
			q_valid <= (q_cnt_q + {3'd0, q_do_push} - {3'd0, q_do_pop}) != 4'd0;
			q_byte <= q_do_pop ? queue_q[q_rd_q + 3'd1] : queue_q[q_rd_q];
			if (q_do_push && (q_cnt_q == {3'd0, q_do_pop}))
				q_byte <= fword_q[31:24];
		end
	end
endmodule // crf_core
